// file: core/sv_access.sv
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps

module sv_access (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic irq_o,
    input wire sv_access_pkg::ctrl_out_t ctrl_i,
    output sv_access_pkg::dev_in_t img_o
);

    sv_access_pkg::top_state_t st_ff;
    sv_access_pkg::top_state_t nxt_st;

    logic hit;
    logic [sv_access_pkg::VAR_IDX_W-1:0] hit_idx;
    logic [sv_access_pkg::VAL_W-1:0] hit_val;
    logic [31:0] sw_word;
    logic fb_wr;
    logic sw_wr;
    logic [sv_access_pkg::IRQ_W-1:0] ev;
    logic [1:0] slot_k;
    logic [2:0] page;

    assign slot_k = addr_i[4:3];
    assign page = addr_i[7:5];

    // ==========================================================
    // shared variable storage
    sv_store u_store (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .name_i(st_ff.name),
        .hit_o(hit),
        .idx_o(hit_idx),
        .value_o(hit_val),
        .fb_wr_i(fb_wr),
        .fb_idx_i(hit_idx),
        .fb_data_i(st_ff.wval),
        .sw_wr_i(sw_wr),
        .sw_idx_i(st_ff.var_sel),
        .sw_data_i(wdata_i),
        .sw_word_o(sw_word)
    );

    assign sw_wr = wr_i && (addr_i == sv_access_pkg::REG_VAR_WORD);

    // ==========================================================
    // next state
    always_comb begin
        nxt_st = st_ff;
        fb_wr = 1'b0;
        ev = '0;
        nxt_st.rdata = '0;

        // ======================================================
        // command engine
        unique case (st_ff.fsm)
            sv_access_pkg::SV_IDLE: begin
                if (st_ff.en && (ctrl_i.sv_cmd != st_ff.cmd_prev)) begin
                    nxt_st.cmd_prev = ctrl_i.sv_cmd;
                    nxt_st.cmd_act = ctrl_i.sv_cmd;
                    nxt_st.name = ctrl_i.sv_name;
                    nxt_st.wval = ctrl_i.sv_wval;
                    nxt_st.wstr = ctrl_i.sv_wstr;
                    nxt_st.fsm = sv_access_pkg::SV_EXEC;
                end
            end
            sv_access_pkg::SV_EXEC: begin
                nxt_st.fsm = sv_access_pkg::SV_IDLE;
                ev[sv_access_pkg::IRQ_DONE] = 1'b1;
                // read field cleared unless this is a read of a known name
                nxt_st.img.sv_rd = '0;
                if (st_ff.cmd_act == sv_access_pkg::CMD_NOP) begin
                    nxt_st.img.sv_status = sv_access_pkg::ST_NULL;
                end else if (st_ff.cmd_act == sv_access_pkg::CMD_READ) begin
                    if (!hit) begin
                        nxt_st.img.sv_status = sv_access_pkg::ST_BAD_NAME;
                    end else begin
                        nxt_st.img.sv_status = sv_access_pkg::ST_OK;
                        // snapshot taken once, sized by the variable
                        for (int b = 0; b < sv_access_pkg::VAL_BYTES; b++) begin
                            if (5'(b) < sv_access_pkg::VAR_LEN[hit_idx]) begin
                                nxt_st.img.sv_rd[8*b +: 8] = hit_val[8*b +: 8];
                            end
                        end
                    end
                end else if (st_ff.cmd_act == sv_access_pkg::CMD_WRITE) begin
                    if (!hit) begin
                        nxt_st.img.sv_status = sv_access_pkg::ST_BAD_NAME;
                    end else if (sv_access_pkg::VAR_PROT[hit_idx]) begin
                        nxt_st.img.sv_status = sv_access_pkg::ST_PROTECTED;
                    end else if (sv_access_pkg::VAR_IS_STR[hit_idx] != st_ff.wstr) begin
                        nxt_st.img.sv_status = sv_access_pkg::ST_BAD_CMD;
                    end else begin
                        fb_wr = 1'b1;
                        ev[sv_access_pkg::IRQ_VWR] = 1'b1;
                        nxt_st.img.sv_status = sv_access_pkg::ST_OK;
                    end
                end else begin
                    nxt_st.img.sv_status = sv_access_pkg::ST_BAD_CMD;
                end
                if (nxt_st.img.sv_status > sv_access_pkg::ST_OK) begin
                    ev[sv_access_pkg::IRQ_FAIL] = 1'b1;
                end
            end
        endcase

        // ======================================================
        // register writes
        if (wr_i) begin
            if (addr_i == sv_access_pkg::REG_CTRL) begin
                nxt_st.en = wdata_i[0];
            end
            if (addr_i == sv_access_pkg::REG_IRQ_STAT) begin
                nxt_st.irq_sts = st_ff.irq_sts & ~wdata_i[sv_access_pkg::IRQ_W-1:0];
            end
            if (addr_i == sv_access_pkg::REG_IRQ_MASK) begin
                nxt_st.irq_mask = wdata_i[sv_access_pkg::IRQ_W-1:0];
            end
            if (addr_i == sv_access_pkg::REG_VAR_SEL) begin
                nxt_st.var_sel = wdata_i[sv_access_pkg::VAR_IDX_W-1:0];
            end
            if (page == sv_access_pkg::PAGE_SLOT && addr_i[1:0] == 2'h0) begin
                if (!addr_i[2]) begin
                    nxt_st.img.slot[slot_k].value = wdata_i;
                end else begin
                    nxt_st.img.slot[slot_k].stat = wdata_i[14:0];
                end
                // both integrity bits flip together with the data
                nxt_st.img.slot[slot_k].lead_integ = ~st_ff.img.slot[slot_k].lead_integ;
                nxt_st.img.slot[slot_k].trail_integ = ~st_ff.img.slot[slot_k].lead_integ;
                nxt_st.img.slot[slot_k].resp = ctrl_i.slot_cmd[slot_k][14:0];
            end
        end

        // set wins over clear
        nxt_st.irq_sts = nxt_st.irq_sts | ev;
        nxt_st.irq = |(nxt_st.irq_sts & nxt_st.irq_mask);

        // ======================================================
        // register reads
        if (rd_i) begin
            if (addr_i == sv_access_pkg::REG_CTRL) begin
                nxt_st.rdata = {31'h0, st_ff.en};
            end else if (addr_i == sv_access_pkg::REG_SV_STAT) begin
                nxt_st.rdata = {15'h0, st_ff.fsm, st_ff.img.sv_status};
            end else if (addr_i == sv_access_pkg::REG_IRQ_STAT) begin
                nxt_st.rdata = {29'h0, st_ff.irq_sts};
            end else if (addr_i == sv_access_pkg::REG_IRQ_MASK) begin
                nxt_st.rdata = {29'h0, st_ff.irq_mask};
            end else if (addr_i == sv_access_pkg::REG_VAR_SEL) begin
                nxt_st.rdata = {30'h0, st_ff.var_sel};
            end else if (addr_i == sv_access_pkg::REG_VAR_WORD) begin
                nxt_st.rdata = sw_word;
            end else if (page == sv_access_pkg::PAGE_SLOT && addr_i[1:0] == 2'h0) begin
                if (!addr_i[2]) begin
                    nxt_st.rdata = st_ff.img.slot[slot_k].value;
                end else begin
                    nxt_st.rdata = {17'h0, st_ff.img.slot[slot_k].stat};
                end
            end else if (page == sv_access_pkg::PAGE_LOAD && addr_i[1:0] == 2'h0) begin
                if (!addr_i[2]) begin
                    nxt_st.rdata = ctrl_i.slot_load[slot_k];
                end else begin
                    nxt_st.rdata = {16'h0, ctrl_i.slot_cmd[slot_k]};
                end
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
            st_ff.fsm <= sv_access_pkg::SV_IDLE;
            st_ff.en <= sv_access_pkg::CTRL_EN_RST;
            st_ff.cmd_prev <= sv_access_pkg::CMD_NOP;
            st_ff.irq_mask <= sv_access_pkg::IRQ_MASK_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata_o = st_ff.rdata;
    assign irq_o = st_ff.irq;
    assign img_o = st_ff.img;

endmodule

// file: core/sv_access_pkg.sv
package sv_access_pkg;

    // ==========================================================
    // sizes
    localparam int NSLOT = 4;
    localparam int NVAR = 4;
    localparam int VAR_IDX_W = 2;
    localparam int VAL_BYTES = 20;
    localparam int VAL_W = 8 * VAL_BYTES;
    localparam int NAME_W = 48;
    localparam int IRQ_W = 3;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SV_STAT = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
    localparam logic [7:0] REG_VAR_SEL = 8'h10;
    localparam logic [7:0] REG_VAR_WORD = 8'h14;
    // slot pages: addr[7:5] selects page, addr[4:3] slot, addr[2] word
    localparam logic [2:0] PAGE_SLOT = 3'h1;
    localparam logic [2:0] PAGE_LOAD = 3'h2;

    // ==========================================================
    // irq bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_FAIL = 1;
    localparam int IRQ_VWR = 2;

    // ==========================================================
    // command and status codes
    localparam logic [15:0] CMD_NOP = 16'h0000;
    localparam logic [15:0] CMD_READ = 16'h0001;
    localparam logic [15:0] CMD_WRITE = 16'h0002;
    localparam logic [15:0] ST_NULL = 16'h0000;
    localparam logic [15:0] ST_OK = 16'h0001;
    localparam logic [15:0] ST_BAD_NAME = 16'h0002;
    localparam logic [15:0] ST_BAD_CMD = 16'h0003;
    localparam logic [15:0] ST_PROTECTED = 16'h0004;

    // ==========================================================
    // shared variable table (names arbitrary)
    localparam logic [NVAR-1:0][NAME_W-1:0] VAR_NAME = {
        48'h7661_7230_3033, 48'h7661_7230_3032, 48'h7661_7230_3031, 48'h7661_7230_3030};
    localparam logic [NVAR-1:0] VAR_IS_STR = 4'ha;
    localparam logic [NVAR-1:0] VAR_PROT = 4'h4;
    localparam logic [NVAR-1:0][4:0] VAR_LEN = {5'h0c, 5'h04, 5'h14, 5'h04};
    localparam logic [VAL_W-1:0] VAR_RST = 160'h0;

    // ==========================================================
    // reset values
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic sign;
        logic [7:0] expo;
        logic [22:0] mant;
    } float_t;

    typedef struct packed {
        logic lead_integ;
        logic [14:0] resp;
        float_t value;
        logic [14:0] stat;
        logic trail_integ;
    } slot_img_t;

    typedef struct packed {
        logic [NSLOT-1:0][15:0] slot_cmd;
        float_t [NSLOT-1:0] slot_load;
        logic [15:0] sv_cmd;
        logic [NAME_W-1:0] sv_name;
        logic [VAL_W-1:0] sv_wval;
        logic sv_wstr;
    } ctrl_out_t;

    typedef struct packed {
        slot_img_t [NSLOT-1:0] slot;
        logic [15:0] sv_status;
        logic [VAL_W-1:0] sv_rd;
    } dev_in_t;

    typedef enum logic [0:0] {
        SV_IDLE = 1'b0,
        SV_EXEC = 1'b1
    } sv_fsm_t;

    typedef struct packed {
        logic [NVAR-1:0][VAL_W-1:0] val;
    } store_state_t;

    typedef struct packed {
        sv_fsm_t fsm;
        logic en;
        logic [15:0] cmd_prev;
        logic [15:0] cmd_act;
        logic [NAME_W-1:0] name;
        logic [VAL_W-1:0] wval;
        logic wstr;
        logic [IRQ_W-1:0] irq_sts;
        logic [IRQ_W-1:0] irq_mask;
        logic [VAR_IDX_W-1:0] var_sel;
        logic [31:0] rdata;
        logic irq;
        dev_in_t img;
    } top_state_t;

endpackage

// file: core/sv_store.sv
`timescale 1ns/1ps

module sv_store (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [sv_access_pkg::NAME_W-1:0] name_i,
    output logic hit_o,
    output logic [sv_access_pkg::VAR_IDX_W-1:0] idx_o,
    output logic [sv_access_pkg::VAL_W-1:0] value_o,
    input wire logic fb_wr_i,
    input wire logic [sv_access_pkg::VAR_IDX_W-1:0] fb_idx_i,
    input wire logic [sv_access_pkg::VAL_W-1:0] fb_data_i,
    input wire logic sw_wr_i,
    input wire logic [sv_access_pkg::VAR_IDX_W-1:0] sw_idx_i,
    input wire logic [31:0] sw_data_i,
    output logic [31:0] sw_word_o
);

    sv_access_pkg::store_state_t st_ff;
    sv_access_pkg::store_state_t nxt_st;
    logic [sv_access_pkg::NVAR-1:0] match;

    // ==========================================================
    // name match per entry
    genvar gi;
    generate
        for (gi = 0; gi < sv_access_pkg::NVAR; gi++) begin : g_match
            assign match[gi] = (name_i == sv_access_pkg::VAR_NAME[gi]);
        end
    endgenerate

    always_comb begin
        hit_o = 1'b0;
        idx_o = '0;
        for (int i = sv_access_pkg::NVAR - 1; i >= 0; i--) begin
            if (match[i]) begin
                hit_o = 1'b1;
                idx_o = sv_access_pkg::VAR_IDX_W'(i);
            end
        end
    end

    assign value_o = st_ff.val[idx_o];
    assign sw_word_o = st_ff.val[sw_idx_i][31:0];

    // ==========================================================
    // storage update, fieldbus write wins over local write
    always_comb begin
        nxt_st = st_ff;
        if (sw_wr_i) begin
            nxt_st.val[sw_idx_i][31:0] = sw_data_i;
        end
        if (fb_wr_i) begin
            nxt_st.val[fb_idx_i] = fb_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < sv_access_pkg::NVAR; i++) begin
                st_ff.val[i] <= sv_access_pkg::VAR_RST;
            end
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule

// file: sim/plc_model.sv
`timescale 1ns/1ps

module plc_model (
    input wire logic clk_sys_i,
    input wire sv_access_pkg::dev_in_t img_i,
    output sv_access_pkg::ctrl_out_t ctrl_o
);
    // ==========================================================
    // output image at time zero
    initial begin
        ctrl_o = '0;
        for (int k = 0; k < 4; k++) begin
            ctrl_o.slot_cmd[k] = 16'h0a00 + 16'(k);
            ctrl_o.slot_load[k] = 32'h4120_0000 + 32'(k);
        end
    end
    // ==========================================================
    // request: name and value set under no-operation, then the code
    task automatic request(input logic [15:0] cmd, input logic [47:0] name, input logic [159:0] val,
        input logic str);
        @(posedge clk_sys_i);
        ctrl_o.sv_cmd <= 16'h0000;
        ctrl_o.sv_name <= name;
        ctrl_o.sv_wval <= val;
        ctrl_o.sv_wstr <= str;
        repeat (4) @(posedge clk_sys_i);
        ctrl_o.sv_cmd <= cmd;
        repeat (4) @(posedge clk_sys_i);
        #1;
    endtask
    // ==========================================================
    // slot read, retried while the integrity bits disagree
    task automatic get_slot(input int k, output sv_access_pkg::float_t v);
        int tries;
        tries = 0;
        #1;
        while (img_i.slot[k].lead_integ !== img_i.slot[k].trail_integ && tries < 4) begin
            @(posedge clk_sys_i);
            tries++;
        end
        v = (tries < 4) ? img_i.slot[k].value : 'x;
    endtask
endmodule

// file: sim/sv_access_monitor.sv
`timescale 1ns/1ps

module sv_access_monitor (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic irq_o,
    input wire sv_access_pkg::ctrl_out_t ctrl_i,
    input wire sv_access_pkg::dev_in_t img_o
);
    // ==========================================================
    // helpers
    logic [3:0] lead;
    logic [3:0] trail;
    logic [3:0] lead_ff;
    logic sw_ff;
    logic [2:0] sa_ff;
    logic [31:0] wd_ff;
    logic en_ff;
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            lead[k] = img_o.slot[k].lead_integ;
            trail[k] = img_o.slot[k].trail_integ;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        lead_ff <= lead;
        sw_ff <= wr_i && addr_i[7:5] == 3'h1 && addr_i[1:0] == 2'b00;
        sa_ff <= addr_i[4:2];
        wd_ff <= wdata_i;
    end
    // engine enable as last written over the bus
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            en_ff <= 1'b1;
        end else if (wr_i && addr_i == 8'h00) begin
            en_ff <= wdata_i[0];
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // ==========================================================
    // assertions
    a_integ_match: assert property (lead == trail)
        else $error("integrity bits differ");
    a_slot_flip: assert property (sw_ff |-> lead[sa_ff[2:1]] != lead_ff[sa_ff[2:1]])
        else $error("slot write without flip");
    a_slot_value: assert property (sw_ff && !sa_ff[0] |-> img_o.slot[sa_ff[2:1]].value == wd_ff)
        else $error("slot value not taken");
    a_status_code: assert property (img_o.sv_status <= 16'h0004)
        else $error("status out of range");
    a_result_hold: assert property ($stable(ctrl_i.sv_cmd) [*4] |=> $stable(img_o.sv_status) && $stable(img_o.sv_rd))
        else $error("result changed without command");
    a_nop_null: assert property ((en_ff && ctrl_i.sv_cmd == 16'h0000) [*4] |-> img_o.sv_status == 16'h0000 && img_o.sv_rd == '0)
        else $error("no-operation not null");
    a_bad_code: assert property (ctrl_i.sv_cmd > 16'h0002 [*4] |-> img_o.sv_status == 16'h0003)
        else $error("unknown code accepted");
    a_read_only: assert property ($changed(img_o.sv_rd) && img_o.sv_rd != '0
        |-> $past(ctrl_i.sv_cmd, 2) == 16'h0001 || $past(ctrl_i.sv_cmd, 3) == 16'h0001)
        else $error("read field filled without read");
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
        else $error("read data outside its cycle");
    c_read_ok: cover property (img_o.sv_status == 16'h0001 && img_o.sv_rd != '0);
    c_protected: cover property (img_o.sv_status == 16'h0004);
    c_irq: cover property (irq_o);
endmodule

bind sv_access sv_access_monitor u_mon (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .ctrl_i(ctrl_i), .img_o(img_o));

// file: sim/testbench.sv
`timescale 1ns/1ps

module testbench;
    localparam logic [47:0] N0 = 48'h7661_7230_3030;
    localparam logic [47:0] N1 = 48'h7661_7230_3031;
    localparam logic [47:0] N2 = 48'h7661_7230_3032;
    localparam logic [47:0] N3 = 48'h7661_7230_3033;
    localparam logic [47:0] NX = 48'h7878_7878_7878;
    localparam logic [31:0] F1 = 32'h3f80_0000;
    localparam logic [159:0] S20 = 160'h5453_5231_5453_5232_5453_5233_5453_5234_5453_5235;
    localparam logic [159:0] S12 = {64'h0, S20[95:0]};
    logic clk_sys_i;
    logic rst_n_i;
    logic [7:0] addr_i;
    logic [31:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [31:0] rdata_o;
    logic irq_o;
    sv_access_pkg::ctrl_out_t ctrl_i;
    sv_access_pkg::dev_in_t img_o;
    int bad_count;
    int total_checks;
    sv_access_pkg::float_t fv;

    sv_access u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .ctrl_i(ctrl_i), .img_o(img_o));
    plc_model u_plc (.clk_sys_i(clk_sys_i), .img_i(img_o), .ctrl_o(ctrl_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // ==========================================================
    // tasks
    task automatic check(input logic [159:0] seen, input logic [159:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, e);
    endtask
    task automatic sv_try(input logic [15:0] c, input logic [47:0] n, input logic [159:0] v, input logic s,
        input logic [15:0] st);
        u_plc.request(c, n, v, s);
        check(img_o.sv_status, st);
        check(img_o.sv_rd, '0);
    endtask
    task automatic sv_read(input logic [47:0] n, input logic [159:0] e);
        u_plc.request(16'h0001, n, '0, 1'b0);
        check(img_o.sv_status, 16'h0001);
        check(img_o.sv_rd, e);
    endtask
    task automatic conclude();
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #50000;
        bad_count++;
        conclude();
    end

    // ==========================================================
    // main sequence
    initial begin
        rst_n_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 32'h0000_0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        bad_count = 0;
        total_checks = 0;
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        reg_wr(8'hfc, 32'hffff_ffff);
        expect_reg(8'hfc, 32'h0000_0000);
        expect_reg(8'h00, 32'h0000_0001);
        expect_reg(8'h0c, 32'h0000_0000);
        expect_reg(8'h08, 32'h0000_0000);
        expect_reg(8'h04, 32'h0000_0000);
        reg_wr(8'h28, 32'h4348_0000);
        u_plc.get_slot(1, fv);
        check(fv, 32'h4348_0000);
        check(img_o.slot[1].resp, 15'h0a01);
        reg_wr(8'h2c, 32'h0000_1234);
        check(img_o.slot[1].stat, 15'h1234);
        expect_reg(8'h48, 32'h4120_0001);
        expect_reg(8'h4c, 32'h0000_0a01);
        sv_try(16'h0002, N0, F1, 1'b0, 16'h0001);
        sv_try(16'h0002, N1, S20, 1'b1, 16'h0001);
        sv_try(16'h0002, N3, S12, 1'b1, 16'h0001);
        sv_try(16'h0002, N2, F1, 1'b0, 16'h0004);
        sv_try(16'h0002, N1, F1, 1'b0, 16'h0003);
        sv_try(16'h0002, N0, S20, 1'b1, 16'h0003);
        sv_try(16'h0001, NX, F1, 1'b0, 16'h0002);
        sv_try(16'h0007, N0, F1, 1'b0, 16'h0003);
        sv_try(16'h0000, N0, F1, 1'b0, 16'h0000);
        expect_reg(8'h08, 32'h0000_0007);
        check(irq_o, 1'b0);
        reg_wr(8'h0c, 32'h0000_0002);
        @(posedge clk_sys_i);
        #1;
        check(irq_o, 1'b1);
        reg_wr(8'h08, 32'h0000_0002);
        @(posedge clk_sys_i);
        #1;
        check(irq_o, 1'b0);
        expect_reg(8'h08, 32'h0000_0005);
        reg_wr(8'h08, 32'h0000_0005);
        sv_read(N1, S20);
        sv_read(N3, S12);
        sv_read(N0, {128'h0, F1});
        expect_reg(8'h04, 32'h0000_0001);
        expect_reg(8'h08, 32'h0000_0001);
        reg_wr(8'h10, 32'h0000_0000);
        reg_wr(8'h14, 32'h4049_0fdb);
        expect_reg(8'h14, 32'h4049_0fdb);
        check(img_o.sv_rd, {128'h0, F1});
        sv_read(N0, {128'h0, 32'h4049_0fdb});
        reg_wr(8'h00, 32'h0000_0000);
        expect_reg(8'h00, 32'h0000_0000);
        u_plc.request(16'h0002, N0, F1, 1'b0);
        check(img_o.sv_status, 16'h0001);
        check(img_o.sv_rd, {128'h0, 32'h4049_0fdb});
        u_plc.request(16'h0001, N0, '0, 1'b0);
        reg_wr(8'h00, 32'h0000_0001);
        expect_reg(8'h14, 32'h4049_0fdb);
        sv_read(N0, {128'h0, 32'h4049_0fdb});
        conclude();
    end
endmodule
